//--- rtl/sample_timing_pkg.sv
// constants, field layouts and state carriers for the sample timing and channel select block
// assumes a classic wishbone slave with 32-bit data; registers sit in the low byte of each word
// Summary of operation
// [R1] controller drives pixel_sync_pulse high for exactly one clock, once per pixel
// [R2] sample taken on first clock edge after pixel_sync_pulse returns low
// [R3] when edge detect enabled, chosen pin edge makes an internal sync pulse
// [R4] internal sync pulse delayed by sync_delay_count clocks; zero adds nothing
// [R5] with edge detect on, sampling follows the internal pulse, not the pin
// [R6] internal sync pulse is exactly one clock wide
// [R7] without selective power-down, global enable powers everything down or up
// [R8] with selective power-down, only blocks with mask bit high are disabled
// [R9] power-down keeps register values and the register interface working
// [R10] line-sequential colour powers down green and blue channels and gain stages
// [R11] line-sequential colour forces monochrome through the red channel
// [R12] monochrome samples only the input chosen by mono_input_select, bits 7:6
// [R13] auto-cycle advances on first clock edge after the pulse pin goes high
// [R14] no force, no auto-cycle: all muxes from colour_select_internal
// [R15] no force, auto-cycle: all muxes cycle red, green, blue together
// [R16] force, no auto-cycle: input from force field, offset/gain internal field
// [R17] force, auto-cycle: input from force field, offset/gain cycle per pulse
// [R18] mode 1 samples three inputs in parallel at 6:1; config 03 or 01 hex
// [R19] single-input modes use 6:1, 3:1, 2:1; mode 4 forbids correlated sampling
// [R20] slow modes need an even clock ratio of at least eight
// [R21] fast_single_mode_sel set only in mode 4
package sample_timing_pkg;
  // register word addresses, byte address bits 7:2
  localparam logic [5:0] ADDR_SETUP1 = 6'h01;
  localparam logic [5:0] ADDR_SETUP3 = 6'h03;
  localparam logic [5:0] ADDR_ACYC_RST = 6'h05;
  localparam logic [5:0] ADDR_SETUP4 = 6'h06;
  localparam logic [5:0] ADDR_SETUP5 = 6'h08;
  localparam logic [5:0] ADDR_SETUP6 = 6'h09;
  localparam logic [5:0] ADDR_STATUS = 6'h0d;
  // reset values
  localparam logic [7:0] RST_SETUP1 = 8'h03;
  localparam logic [7:0] RST_SETUP3 = 8'h1f;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // setup_config_1 fields
  localparam int S1_EN = 0;
  localparam int S1_CDS = 1;
  localparam int S1_MONO = 2;
  localparam int S1_SELECTIVE_POWERDOWN_EN = 3;
  localparam int S1_FAST = 6;
  // setup_config_3 fields
  localparam int S3_CHAN_LO = 6;
  // setup_config_4 fields
  localparam int S4_LINE = 0;
  localparam int S4_ACYC = 1;
  localparam int S4_FME = 2;
  localparam int S4_INTM_LO = 4;
  localparam int S4_FM_LO = 6;
  // setup_config_5 fields
  localparam int S5_DET = 0;
  localparam int S5_DEL_LO = 1;
  localparam int S5_POL = 4;
  // write masks for setup_config_5, setup_config_6 and setup_config_1
  localparam logic [7:0] S5_MASK = 8'h1f;
  localparam logic [7:0] S6_MASK = 8'h0f;
  localparam logic [7:0] S1_MASK = 8'h7f;
  // colour codes
  localparam logic [1:0] COL_RED = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_BLUE = 2'h2;
  // power block indices: red, green, blue channels, converter
  localparam int NBLK = 4;
  localparam logic [3:0] GB_BLOCKS = 4'h6;
  localparam logic [2:0] DEL_ZERO = 3'h0;

  // sync pipeline states, gray along idle, delay, fire
  typedef enum logic [1:0] {
    SYN_IDLE = 2'b00,
    SYN_WAIT = 2'b01,
    SYN_FIRE = 2'b11
  } sync_state_t;

  typedef struct packed {
    logic [7:0] setup1;
    logic [7:0] setup3;
    logic [7:0] setup4;
    logic [7:0] setup5;
    logic [7:0] setup6;
  } cfg_t;

  typedef struct packed {
    cfg_t cfg;
    sync_state_t sst;
    logic [2:0] dcnt;
    logic pin_q;
    logic pulse;
    logic sync_prev;
    logic sample;
    logic acyc_prev;
    logic [1:0] cyc_col;
    logic ack;
    logic [31:0] rdat;
    logic [1:0] in_sel;
    logic [1:0] og_sel;
    logic mono;
    logic [3:0] pwr_dn;
  } state_t;

  typedef struct packed {
    logic [1:0] input_sel;
    logic [1:0] offset_gain_sel;
    logic mono;
    logic parallel_sample;
    logic [3:0] power_down;
  } chan_ctrl_t;
endpackage : sample_timing_pkg

//--- rtl/sample_timing_ctrl.sv
// sample timing, sync edge detect, channel selection and power gating
// assumes pins are synchronous to clk_i and a classic wishbone master on the register side
`timescale 1ns/100ps
module sample_timing_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic pixel_sync_pulse_i,
  input wire logic autocycle_pulse_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sample_strobe_o,
  output sample_timing_pkg::chan_ctrl_t chan_o
);

  sample_timing_pkg::state_t s_q;
  sample_timing_pkg::state_t s_d;
  logic req;
  logic wr;
  logic [5:0] widx;
  logic edge_seen;
  logic sync_src;
  logic acyc_adv;
  logic [1:0] next_col;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and event terms
  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign widx = wb_adr_i[7:2];
  // edge on the registered pin copy, polarity picked by config
  assign edge_seen = s_q.cfg.setup5[sample_timing_pkg::S5_POL]
                     ? (pixel_sync_pulse_i && !s_q.pin_q)
                     : (!pixel_sync_pulse_i && s_q.pin_q); // R3
  // internal pulse replaces the pin when detection is on
  assign sync_src = s_q.cfg.setup5[sample_timing_pkg::S5_DET]
                    ? s_q.pulse : pixel_sync_pulse_i; // R5
  assign acyc_adv = autocycle_pulse_pin_i && !s_q.acyc_prev; // R13
  assign next_col = (s_q.cyc_col == sample_timing_pkg::COL_BLUE)
                    ? sample_timing_pkg::COL_RED : s_q.cyc_col + 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [2:0] del;
    logic line;
    logic [3:0] pd;
    s_d = s_q;
    del = s_q.cfg.setup5[sample_timing_pkg::S5_DEL_LO +: 3];
    line = s_q.cfg.setup4[sample_timing_pkg::S4_LINE];
    pd = '0;
    // register writes; power-down never touches these, so values persist
    s_d.ack = req; // R9
    if (wr)
    begin
      case (widx)
        sample_timing_pkg::ADDR_SETUP1:
          s_d.cfg.setup1 = wb_dat_i[7:0] & sample_timing_pkg::S1_MASK;
        sample_timing_pkg::ADDR_SETUP3: s_d.cfg.setup3 = wb_dat_i[7:0];
        sample_timing_pkg::ADDR_SETUP4: s_d.cfg.setup4 = wb_dat_i[7:0];
        sample_timing_pkg::ADDR_SETUP5:
          s_d.cfg.setup5 = wb_dat_i[7:0] & sample_timing_pkg::S5_MASK;
        sample_timing_pkg::ADDR_SETUP6:
          s_d.cfg.setup6 = wb_dat_i[7:0] & sample_timing_pkg::S6_MASK;
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    // read data, unmapped words read zero
    s_d.rdat = '0;
    if (req && !wb_we_i)
    begin
      case (widx)
        sample_timing_pkg::ADDR_SETUP1: s_d.rdat[7:0] = s_q.cfg.setup1;
        sample_timing_pkg::ADDR_SETUP3: s_d.rdat[7:0] = s_q.cfg.setup3;
        sample_timing_pkg::ADDR_SETUP4: s_d.rdat[7:0] = s_q.cfg.setup4;
        sample_timing_pkg::ADDR_SETUP5: s_d.rdat[7:0] = s_q.cfg.setup5;
        sample_timing_pkg::ADDR_SETUP6: s_d.rdat[7:0] = s_q.cfg.setup6;
        sample_timing_pkg::ADDR_STATUS:
          s_d.rdat[7:0] = {s_q.pwr_dn, s_q.og_sel, s_q.in_sel};
        default: s_d.rdat = '0;
      endcase
    end

    // edge detect and delay pipeline; a new edge during a delay is dropped
    s_d.pin_q = pixel_sync_pulse_i;
    s_d.pulse = 1'b0;
    case (s_q.sst)
      sample_timing_pkg::SYN_IDLE:
      begin
        if (s_q.cfg.setup5[sample_timing_pkg::S5_DET] && edge_seen) // R3
        begin
          if (del == sample_timing_pkg::DEL_ZERO)
          begin
            s_d.pulse = 1'b1; // R4 R6
            s_d.sst = sample_timing_pkg::SYN_FIRE;
          end
          else
          begin
            s_d.dcnt = del - 3'h1;
            s_d.sst = sample_timing_pkg::SYN_WAIT;
          end
        end
      end
      sample_timing_pkg::SYN_WAIT:
      begin
        if (s_q.dcnt == sample_timing_pkg::DEL_ZERO)
        begin
          s_d.pulse = 1'b1; // R4 R6
          s_d.sst = sample_timing_pkg::SYN_FIRE;
        end
        else
        begin
          s_d.dcnt = s_q.dcnt - 3'h1;
        end
      end
      sample_timing_pkg::SYN_FIRE: s_d.sst = sample_timing_pkg::SYN_IDLE;
      default: s_d.sst = sample_timing_pkg::SYN_IDLE;
    endcase

    // sample strobe on the first edge after the sync falls
    s_d.sync_prev = sync_src;
    s_d.sample = s_q.sync_prev && !sync_src; // R2 R5

    // auto-cycle colour counter, restart via its reset word
    s_d.acyc_prev = autocycle_pulse_pin_i;
    if (wr && widx == sample_timing_pkg::ADDR_ACYC_RST)
      s_d.cyc_col = sample_timing_pkg::COL_RED;
    else if (s_q.cfg.setup4[sample_timing_pkg::S4_ACYC] && acyc_adv)
      s_d.cyc_col = next_col; // R13 R15 R17

    // channel mux selection table
    case ({s_q.cfg.setup4[sample_timing_pkg::S4_FME],
           s_q.cfg.setup4[sample_timing_pkg::S4_ACYC]})
      2'b00:
      begin
        s_d.in_sel = s_q.cfg.setup4[sample_timing_pkg::S4_INTM_LO +: 2]; // R14
        s_d.og_sel = s_q.cfg.setup4[sample_timing_pkg::S4_INTM_LO +: 2];
      end
      2'b01:
      begin
        s_d.in_sel = s_d.cyc_col; // R15
        s_d.og_sel = s_d.cyc_col;
      end
      2'b10:
      begin
        s_d.in_sel = s_q.cfg.setup4[sample_timing_pkg::S4_FM_LO +: 2]; // R16
        s_d.og_sel = s_q.cfg.setup4[sample_timing_pkg::S4_INTM_LO +: 2];
      end
      default:
      begin
        s_d.in_sel = s_q.cfg.setup4[sample_timing_pkg::S4_FM_LO +: 2]; // R17
        s_d.og_sel = s_d.cyc_col;
      end
    endcase
    // outside line mode, mono input comes from setup3 bits 7:6
    if (!line)
      s_d.in_sel = s_q.cfg.setup3[sample_timing_pkg::S3_CHAN_LO +: 2]; // R12
    s_d.mono = line || s_q.cfg.setup1[sample_timing_pkg::S1_MONO]; // R11

    // power-down per block
    if (s_q.cfg.setup1[sample_timing_pkg::S1_SELECTIVE_POWERDOWN_EN])
      pd = s_q.cfg.setup6[3:0]; // R8
    else
      pd = {sample_timing_pkg::NBLK{!s_q.cfg.setup1[sample_timing_pkg::S1_EN]}}; // R7
    if (line)
      pd = pd | sample_timing_pkg::GB_BLOCKS; // R10
    s_d.pwr_dn = pd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
      s_q.cfg.setup1 <= sample_timing_pkg::RST_SETUP1;
      s_q.cfg.setup3 <= sample_timing_pkg::RST_SETUP3;
      s_q.sst <= sample_timing_pkg::SYN_IDLE;
    end
    else if (clk_en_i)
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; correlated sampling and ratio choice are software's job (R18..R21)
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign sample_strobe_o = s_q.sample;
  assign chan_o.input_sel = s_q.in_sel;
  assign chan_o.offset_gain_sel = s_q.og_sel;
  assign chan_o.mono = s_q.mono;
  assign chan_o.parallel_sample = !s_q.mono; // R18
  assign chan_o.power_down = s_q.pwr_dn;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !clk_en_i);

  a_pulse_one_wide: assert property (s_q.pulse |=> !s_q.pulse) // R6
    else $error("internal sync pulse wider than one clock");
  a_sample_after_fall: assert property
    ($fell(sync_src) && $past(clk_en_i) |=> sample_strobe_o) // R2
    else $error("no sample after sync fall");
  a_zero_delay: assert property (s_q.sst == sample_timing_pkg::SYN_IDLE
    && s_q.cfg.setup5[0] && edge_seen && s_q.cfg.setup5[3:1] == 3'h0 ##1 clk_en_i
    |-> s_q.pulse) // R4
    else $error("zero delay pulse late");
  a_edge_makes_pulse: assert property (s_q.sst == sample_timing_pkg::SYN_IDLE
    && s_q.cfg.setup5[0] && edge_seen |=> s_q.sst != sample_timing_pkg::SYN_IDLE) // R3
    else $error("edge not detected");
  a_line_gb_down: assert property (s_q.cfg.setup4[0] ##1 clk_en_i
    |-> chan_o.power_down[2:1] == 2'b11) // R10
    else $error("green/blue not powered down");
  a_line_forces_mono: assert property (s_q.cfg.setup4[0] |=> chan_o.mono) // R11
    else $error("line mode not mono");
  a_sel_power: assert property (s_q.cfg.setup1[3] && !s_q.cfg.setup4[0]
    |=> chan_o.power_down == $past(s_q.cfg.setup6[3:0])) // R8
    else $error("selective power mismatch");
  a_glob_power: assert property (!s_q.cfg.setup1[3] && !s_q.cfg.setup4[0]
    |=> chan_o.power_down == {4{!$past(s_q.cfg.setup1[0])}}) // R7
    else $error("global power mismatch");
  a_acyc_step: assert property (s_q.cfg.setup4[1] && acyc_adv
    && !(wr && widx == sample_timing_pkg::ADDR_ACYC_RST) |=> s_q.cyc_col == $past(next_col)) // R13
    else $error("auto-cycle did not advance");
  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o) // R9
    else $error("ack held too long");

  c_delayed_pulse: cover property (s_q.sst == sample_timing_pkg::SYN_WAIT ##[1:8] s_q.pulse);
  c_autocycle: cover property (s_q.cyc_col == sample_timing_pkg::COL_BLUE ##[1:50]
    s_q.cyc_col == sample_timing_pkg::COL_RED);
  c_sample: cover property (sample_strobe_o);
endmodule : sample_timing_ctrl

//--- verification/sync_source.sv
// model of the scanner timing controller that drives the sync pin
// assumes the block samples the pin on clk_i; the pin idles low while the model is stopped
`timescale 1ns/100ps
module sync_source (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic square_i,
  input wire logic [3:0] period_i,
  output logic sync_o
);
  logic [3:0] cnt_q = 4'h0;
  logic sync_q = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // period counter restarts whenever the model is stopped, so each run starts aligned
  always_ff @(posedge clk_i)
  begin
    if (!run_i || cnt_q >= period_i - 4'h1)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end

  // pulse mode gives a one clock pulse per period; square mode a wave high for the first half of each period
  always_ff @(posedge clk_i)
  begin
    sync_q <= run_i && (square_i ? (cnt_q < (period_i >> 1)) : (cnt_q == 4'h0));
  end

  assign sync_o = sync_q;
endmodule : sync_source

//--- verification/sample_timing_ctrl_tb.sv
// self-checking testbench for the sample timing and channel select block
// assumes the sync source model is compiled alongside; clock 40 MHz, wishbone classic
`timescale 1ns/100ps
module sample_timing_ctrl_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic en = 1'b1;
  logic acyc = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic strobe;
  logic sync;
  logic run = 1'b0;
  logic square = 1'b0;
  logic [3:0] period = 4'h6;
  sample_timing_pkg::chan_ctrl_t chan;
  logic mon_en = 1'b0;
  logic pol = 1'b1;
  logic prev = 1'b0;
  logic last_st = 1'b0;
  logic [1:0] c;
  int error_cnt = 0;
  int checked = 0;
  int cnt = 0;
  int nst = 0;
  int exp_lat = 0;
  int m;
  int p;

  always #12.5 clk_i = ~clk_i;

  sample_timing_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(en),
    .pixel_sync_pulse_i(sync), .autocycle_pulse_pin_i(acyc), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sample_strobe_o(strobe), .chan_o(chan));

  sync_source model (.clk_i(clk_i), .run_i(run), .square_i(square), .period_i(period),
    .sync_o(sync));

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("bus ack", 32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check("register read", q, {24'h0, e});
  endtask : rd

  // whole channel word, parallel sampling expected only outside mono
  task automatic chan_is(input logic [9:0] e);
    repeat (3) @(posedge clk_i);
    check("channel control", {22'h0, chan}, {22'h0, e});
  endtask : chan_is

  task automatic pulse_acyc;
    @(posedge clk_i);
    acyc <= 1'b1;
    @(posedge clk_i);
    acyc <= 1'b0;
  endtask : pulse_acyc

  // a window of six whole periods must hold exactly six strobes
  task automatic run_sync(input logic sq, input logic [3:0] per, input int lat, input logic pe);
    @(posedge clk_i);
    square <= sq;
    period <= per;
    pol <= pe;
    exp_lat <= lat;
    run <= 1'b1;
    nst = 0;
    repeat (2 * per) @(posedge clk_i);
    mon_en <= 1'b1;
    repeat (6 * per) @(posedge clk_i);
    mon_en <= 1'b0;
    run <= 1'b0;
    repeat (2 * per) @(posedge clk_i);
    check("strobe count", nst, 6);
  endtask : run_sync

  ////////////////////////////////////////////////////////////////////////////////////////////
  // latency counted from the chosen pin edge; a stuck-high strobe shows as width error
  always @(posedge clk_i)
  begin
    if (sync !== prev && sync === pol) cnt = 0;
    else cnt++;
    prev = sync;
    if (mon_en && strobe === 1'b1)
    begin
      nst++;
      check("strobe latency", cnt, exp_lat);
      check("strobe width", {31'h0, last_st}, 32'h0);
    end
    last_st = strobe;
  end

  // watchdog sized well beyond the several hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(sample_timing_pkg::ADDR_SETUP1, sample_timing_pkg::RST_SETUP1);
    rd(sample_timing_pkg::ADDR_SETUP3, sample_timing_pkg::RST_SETUP3);
    rd(6'h3f, 8'h00);
    wr(sample_timing_pkg::ADDR_SETUP5, 8'hff);
    rd(sample_timing_pkg::ADDR_SETUP5, 8'h1f);
    wr(sample_timing_pkg::ADDR_SETUP5, 8'h00);
    chan_is(10'h010);
    // power gating, then register contents survive power-down
    wr(sample_timing_pkg::ADDR_SETUP1, 8'h00);
    chan_is(10'h01f);
    rd(sample_timing_pkg::ADDR_SETUP3, sample_timing_pkg::RST_SETUP3);
    wr(sample_timing_pkg::ADDR_SETUP6, 8'h05);
    wr(sample_timing_pkg::ADDR_SETUP1, 8'h08);
    chan_is(10'h015);
    wr(sample_timing_pkg::ADDR_SETUP1, 8'h09);
    chan_is(10'h015);
    rd(sample_timing_pkg::ADDR_SETUP6, 8'h05);
    wr(sample_timing_pkg::ADDR_SETUP6, 8'h00);
    wr(sample_timing_pkg::ADDR_SETUP1, 8'h05);
    wr(sample_timing_pkg::ADDR_SETUP3, 8'h80);
    chan_is(10'h220);
    // line mode with every force and auto-cycle combination
    wr(sample_timing_pkg::ADDR_SETUP1, 8'h01);
    for (m = 0; m < 4; m++)
    begin
      wr(sample_timing_pkg::ADDR_ACYC_RST, 8'h00);
      wr(sample_timing_pkg::ADDR_SETUP4, {2'h2, 2'h1, 1'b0, m[1], m[0], 1'b1});
      for (p = 0; p <= (m[0] ? 3 : 0); p++)
      begin
        if (p > 0) pulse_acyc();
        c = 2'(p % 3);
        chan_is({m[1] ? 2'h2 : (m[0] ? c : 2'h1), m[0] ? c : 2'h1, 6'h26});
      end
    end
    // a pulse while the clock enable is low must not move the colour
    @(posedge clk_i);
    en <= 1'b0;
    pulse_acyc();
    chan_is(10'h226);
    en <= 1'b1;
    chan_is(10'h226);
    wr(sample_timing_pkg::ADDR_SETUP4, 8'h00);
    wr(sample_timing_pkg::ADDR_SETUP1, 8'h03);
    // sync from the pin, then from detected edges with boundary delays
    run_sync(1'b0, 4'h6, 2, 1'b1);
    wr(sample_timing_pkg::ADDR_SETUP5, 8'h11);
    run_sync(1'b1, 4'he, 3, 1'b1);
    wr(sample_timing_pkg::ADDR_SETUP5, 8'h1f);
    run_sync(1'b1, 4'he, 10, 1'b1);
    wr(sample_timing_pkg::ADDR_SETUP5, 8'h05);
    run_sync(1'b1, 4'he, 5, 1'b0);
    end_of_test();
  end
endmodule : sample_timing_ctrl_tb
